// [design/sleep_mask_pkg.sv]
// Package with register map, reset values and carrier types of the sleep-state error mask bank.
package sleep_mask_pkg;

   localparam logic [7:0] S3_ANALOG_TEMP_OFFSET  = 8'he9;
   localparam logic [7:0] S45_INPUT_OFFSET       = 8'hea;
   localparam logic [7:0] S45_ANALOG_TEMP_OFFSET = 8'heb;

   localparam logic [7:0] ANALOG_TEMP_RESET      = 8'h07;
   localparam logic [7:0] INPUT_MASK_RESET       = 8'hff;
   localparam logic [7:0] ANALOG_TEMP_WRITABLE   = 8'h0f;

   // Field positions inside the analog/temperature mask registers.
   localparam int ANALOG12_BIT  = 0;
   localparam int ANALOG13_BIT  = 1;
   localparam int ANALOG14_BIT  = 2;
   localparam int ZONE_TEMP_BIT = 3;

   // Sleep state reported by the power manager.
   typedef enum logic [1:0] {
      SLEEP_AWAKE,
      SLEEP_S1,
      SLEEP_S3,
      SLEEP_S45
   } sleep_state_e;

   // Raw error events of the sources that these masks cover.
   typedef struct packed {
      logic [7:0] generalPurposeInput;
      logic [2:0] analogInput;
      logic [1:0] zoneTemp;
      logic [1:0] zoneDiodeFault;
   } error_events_s;

   // Register write/read request from the serial host interface.
   typedef struct packed {
      logic       writeEn;
      logic       readEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

endpackage : sleep_mask_pkg

// [design/mask_reg.sv]
// One byte-wide mask register with a reset value and a mask of writable bits.
`timescale 1ns/100ps
module mask_reg
   import sleep_mask_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITABLE    = 8'hff
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       wrEn,
   input  wire logic [7:0] wdata,
   output logic      [7:0] value
);

   // Bits outside WRITABLE load zero on every write, whatever wdata holds.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         value <= RESET_VALUE;
      end else if (wrEn) begin
         value <= wdata & WRITABLE;
      end
   end

endmodule : mask_reg

// [design/sleep_state_error_mask.sv]
// Sleep-state error mask bank: three mask registers and the masking of error events.
//
// Function
// - S3 analog bits 0-2 suppress analog inputs twelve to fourteen errors in S3.
// - S3 analog bit 3 suppresses zone 1/2 temperature and diode faults in S3.
// - S4/S5 input bit n suppresses general-purpose input n errors in S4/S5.
// - S4/S5 analog bits 0-2 suppress analog inputs twelve to fourteen in S4/S5.
// - S4/S5 analog bit 3 suppresses zone 1/2 temperature and diode faults there.
// - Both analog/temperature registers reset to 07h; upper bits reserved, read-only.
// - S4/S5 input mask register resets to FFh.
//
// The bank sits between the raw limit comparators and the error status logic.
// Every error event passes through one register stage, so a status bit sees it
// one clock after the comparator raised it. The extra cycle is cheap and keeps
// every port on a flip-flop, which eases timing towards the status registers.
//
// A mask only bites while the power manager reports its own sleep state. While
// awake or in S1 every event passes untouched, whatever the masks hold, so
// software may load the sleep masks long before the system goes to sleep.
//
// The temperature bit of each analog register masks both zones together, and
// masks the temperature limit errors and the diode faults alike. There is no
// way to mask one zone alone in a sleep state; the general masks do that.
//
// Reserved bits of the analog registers reset to zero and load zero on every write, so they read
// zero and a write of ones to them leaves no trace.
`timescale 1ns/100ps
module sleep_state_error_mask
   import sleep_mask_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire reg_req_s      regReq,
   input  wire sleep_state_e  sleepState,
   input  wire error_events_s errorIn,
   output error_events_s      errorOut,
   output logic [7:0]         rdata,
   output logic               rdataValid
);

   logic [7:0]    s3AnalogTemp;
   logic [7:0]    s45Input;
   logic [7:0]    s45AnalogTemp;
   logic [7:0]    rdata_nxt;
   error_events_s errorOut_nxt;
   error_events_s suppress;
   wire           inS3  = (sleepState == SLEEP_S3);
   wire           inS45 = (sleepState == SLEEP_S45);

   // Address decode of the three write strobes.
   // A write and a read in the same cycle read the old value, as the read mux
   // looks at the register outputs before the edge loads them.
   wire wrS3A  = regReq.writeEn && (regReq.addr == S3_ANALOG_TEMP_OFFSET);
   wire wrS45I = regReq.writeEn && (regReq.addr == S45_INPUT_OFFSET);
   wire wrS45A = regReq.writeEn && (regReq.addr == S45_ANALOG_TEMP_OFFSET);

   mask_reg #(.RESET_VALUE(ANALOG_TEMP_RESET), .WRITABLE(ANALOG_TEMP_WRITABLE)) s3AnalogTempReg (
      .clk   (clk),
      .rstn  (rstn),
      .wrEn  (wrS3A),
      .wdata (regReq.wdata),
      .value (s3AnalogTemp)
   );

   mask_reg #(.RESET_VALUE(INPUT_MASK_RESET), .WRITABLE(8'hff)) s45InputReg (
      .clk   (clk),
      .rstn  (rstn),
      .wrEn  (wrS45I),
      .wdata (regReq.wdata),
      .value (s45Input)
   );

   mask_reg #(.RESET_VALUE(ANALOG_TEMP_RESET), .WRITABLE(ANALOG_TEMP_WRITABLE)) s45AnalogTempReg (
      .clk   (clk),
      .rstn  (rstn),
      .wrEn  (wrS45A),
      .wdata (regReq.wdata),
      .value (s45AnalogTemp)
   );

   // Read mux; unmapped addresses read zero, and reserved bits always hold zero.
   assign rdata_nxt = (regReq.addr == S3_ANALOG_TEMP_OFFSET)  ? s3AnalogTemp :
                      (regReq.addr == S45_INPUT_OFFSET)       ? s45Input :
                      (regReq.addr == S45_ANALOG_TEMP_OFFSET) ? s45AnalogTemp : 8'h00;

   // Suppression terms; a mask only bites in its own sleep state.
   assign suppress.generalPurposeInput = inS45 ? s45Input : 8'h00;
   assign suppress.analogInput = inS3  ? s3AnalogTemp[ANALOG14_BIT:ANALOG12_BIT] :
                                 inS45 ? s45AnalogTemp[ANALOG14_BIT:ANALOG12_BIT] : 3'h0;
   assign suppress.zoneTemp = {2{(inS3 && s3AnalogTemp[ZONE_TEMP_BIT])
                               || (inS45 && s45AnalogTemp[ZONE_TEMP_BIT])}};
   assign suppress.zoneDiodeFault = suppress.zoneTemp;
   assign errorOut_nxt = errorIn & ~suppress;

   // Outputs registered so that every port comes straight from a flip-flop.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         errorOut   <= '0;
         rdata      <= 8'h00;
         rdataValid <= 1'b0;
      end else begin
         errorOut   <= errorOut_nxt;
         rdata      <= rdata_nxt;
         rdataValid <= regReq.readEn;
      end
   end

   // Checks. Each one but AST_RESERVED looks one cycle ahead, as the output stage delays every event by one clock.

   // Steps of a write to the input mask followed at once by a read of it.
   sequence seqWriteInput;
      wrS45I;
   endsequence

   sequence seqReadInput;
      regReq.addr == S45_INPUT_OFFSET && !regReq.writeEn;
   endsequence

   // Analog masks in S3, one assertion per input.
   AST_S3_ANALOG: assert property (@(posedge clk) disable iff (!rstn)
      inS3 && s3AnalogTemp[ANALOG12_BIT] |=> !errorOut.analogInput[0])
      else $error("Analog twelve error passed while masked in S3.");
   AST_S3_ANALOG13: assert property (@(posedge clk) disable iff (!rstn)
      inS3 && s3AnalogTemp[ANALOG13_BIT] |=> !errorOut.analogInput[1])
      else $error("Analog thirteen error passed while masked in S3.");
   AST_S3_ANALOG14: assert property (@(posedge clk) disable iff (!rstn)
      inS3 && s3AnalogTemp[ANALOG14_BIT] |=> !errorOut.analogInput[2])
      else $error("Analog fourteen error passed while masked in S3.");

   // Zone masks in S3 cover temperature and diode faults of both zones.
   AST_S3_TEMP: assert property (@(posedge clk) disable iff (!rstn)
      inS3 && s3AnalogTemp[ZONE_TEMP_BIT] |=> errorOut.zoneTemp == 2'b00 && errorOut.zoneDiodeFault == 2'b00)
      else $error("Zone error passed while masked in S3.");

   // Input masks act in S4/S5 only.
   AST_S45_INPUT: assert property (@(posedge clk) disable iff (!rstn)
      inS45 |=> (errorOut.generalPurposeInput & $past(s45Input)) == 8'h00)
      else $error("Input error passed while masked in S4/S5.");
   AST_S3_INPUT_PASS: assert property (@(posedge clk) disable iff (!rstn)
      inS3 |=> errorOut.generalPurposeInput == $past(errorIn.generalPurposeInput))
      else $error("Input error suppressed in S3.");

   // Analog masks in S4/S5, one assertion per input.
   AST_S45_ANALOG12: assert property (@(posedge clk) disable iff (!rstn)
      inS45 && s45AnalogTemp[ANALOG12_BIT] |=> !errorOut.analogInput[0])
      else $error("Analog twelve error passed while masked in S4/S5.");
   AST_S45_ANALOG13: assert property (@(posedge clk) disable iff (!rstn)
      inS45 && s45AnalogTemp[ANALOG13_BIT] |=> !errorOut.analogInput[1])
      else $error("Analog thirteen error passed while masked in S4/S5.");
   AST_S45_ANALOG: assert property (@(posedge clk) disable iff (!rstn)
      inS45 && s45AnalogTemp[ANALOG14_BIT] |=> !errorOut.analogInput[2])
      else $error("Analog fourteen error passed while masked in S4/S5.");

   // Zone masks in S4/S5, temperature and diode faults apart.
   AST_S45_TEMP: assert property (@(posedge clk) disable iff (!rstn)
      inS45 && s45AnalogTemp[ZONE_TEMP_BIT] |=> errorOut.zoneTemp == 2'b00)
      else $error("Zone error passed while masked in S4/S5.");
   AST_S45_DIODE: assert property (@(posedge clk) disable iff (!rstn)
      inS45 && s45AnalogTemp[ZONE_TEMP_BIT] |=> errorOut.zoneDiodeFault == 2'b00)
      else $error("Diode fault passed while masked in S4/S5.");

   // Register side: reserved bits, read-back and the read strobe.
   AST_RESERVED: assert property (@(posedge clk) disable iff (!rstn)
      s3AnalogTemp[7:4] == 4'h0 && s45AnalogTemp[7:4] == 4'h0)
      else $error("Reserved mask bits are not zero.");
   AST_WRITE_READ: assert property (@(posedge clk) disable iff (!rstn)
      seqWriteInput ##1 seqReadInput |=> rdata == $past(regReq.wdata, 2))
      else $error("Input mask did not read back as written.");
   AST_READ_VALID: assert property (@(posedge clk) disable iff (!rstn)
      regReq.readEn |=> rdataValid)
      else $error("Read strobe not answered.");
   AST_NO_READ_VALID: assert property (@(posedge clk) disable iff (!rstn)
      !regReq.readEn |=> !rdataValid)
      else $error("Read data flagged without a read.");
   AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rstn)
      regReq.addr != S3_ANALOG_TEMP_OFFSET && regReq.addr != S45_INPUT_OFFSET
      && regReq.addr != S45_ANALOG_TEMP_OFFSET |=> rdata == 8'h00)
      else $error("Unmapped address did not read zero.");

   // Outside their states the masks leave every event alone, and no event is ever made up.
   AST_AWAKE_PASS: assert property (@(posedge clk) disable iff (!rstn)
      sleepState == SLEEP_AWAKE |=> errorOut == $past(errorIn))
      else $error("Error suppressed while awake.");
   AST_S1_PASS: assert property (@(posedge clk) disable iff (!rstn)
      sleepState == SLEEP_S1 |=> errorOut == $past(errorIn))
      else $error("Error suppressed in S1.");
   AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> (errorOut & ~$past(errorIn)) == '0)
      else $error("Error reported that was never raised.");

endmodule : sleep_state_error_mask

// [bench/sleep_state_error_mask_test.sv]
// Self-checking testbench of the sleep-state error mask bank.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module sleep_state_error_mask_test
   import sleep_mask_pkg::*;
;
   logic          clk        = 1'b0;
   logic          rstn       = 1'b0;
   reg_req_s      regReq     = '0;
   sleep_state_e  sleepState = SLEEP_AWAKE;
   error_events_s errorIn    = '0;
   error_events_s errorOut;
   logic [7:0]    rdata;
   logic          rdataValid;
   int            bad_count  = 0;
   int            n_checks   = 0;
   int            cycles     = 0;

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   sleep_state_error_mask i_dut (
      .clk        (clk),
      .rstn       (rstn),
      .regReq     (regReq),
      .sleepState (sleepState),
      .errorIn    (errorIn),
      .errorOut   (errorOut),
      .rdata      (rdata),
      .rdataValid (rdataValid)
   );

   // The run needs under a hundred cycles, well below the 2000-cycle ceiling that cuts a hang.
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         bad_count++;
         final_report();
      end
   end

   // Expected output with every raw event raised: a source survives unless its mask is set in its state.
   function automatic error_events_s expf(input sleep_state_e s, input logic [7:0] a3, g, a45);
      error_events_s e;
      logic [3:0]    m;
      e = '1;
      m = (s == SLEEP_S3) ? a3[3:0] : (s == SLEEP_S45) ? a45[3:0] : 4'h0;
      if (s == SLEEP_S45) e.generalPurposeInput = ~g;
      e.analogInput    = ~m[2:0];
      e.zoneTemp       = {2{~m[3]}};
      e.zoneDiodeFault = {2{~m[3]}};
      return e;
   endfunction : expf

   // One-cycle write request, released after the sampling edge.
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      #1 regReq = '{writeEn: 1'b1, readEn: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      #1 regReq = '0;
      `CHK("rdataValid", 1'b0, rdataValid)
   endtask : wr

   // Write followed at once by a read of the same address; the read sees the new value.
   task automatic wrrd(input logic [7:0] a, d, exp);
      @(posedge clk);
      #1 regReq = '{writeEn: 1'b1, readEn: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      #1 regReq = '{writeEn: 1'b0, readEn: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1 regReq = '0;
      `CHK("rdata", exp, rdata)
   endtask : wrrd

   // One-cycle read request; data and valid are checked just after the sampling edge that registers them.
   task automatic rd(input logic [7:0] a, exp);
      @(posedge clk);
      #1 regReq = '{writeEn: 1'b0, readEn: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1 regReq = '0;
      `CHK("rdata", exp, rdata)
      `CHK("rdataValid", 1'b1, rdataValid)
   endtask : rd

   // Writes all three masks, reads them back, then raises every event in each sleep state.
   task automatic sweep(input logic [7:0] a3, g, a45);
      wr(S3_ANALOG_TEMP_OFFSET, a3);
      wr(S45_INPUT_OFFSET, g);
      wr(S45_ANALOG_TEMP_OFFSET, a45);
      rd(S3_ANALOG_TEMP_OFFSET, a3 & 8'h0f);
      rd(S45_INPUT_OFFSET, g);
      rd(S45_ANALOG_TEMP_OFFSET, a45 & 8'h0f);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         #1 sleepState = sleep_state_e'(s);
         errorIn = '1;
         @(posedge clk);
         #1 `CHK("errorOut", expf(sleepState, a3, g, a45), errorOut)
      end
   endtask : sweep

   // Reset values of the three masks and a read of an unmapped address.
   task automatic defaults();
      rd(S3_ANALOG_TEMP_OFFSET, 8'h07);
      rd(S45_INPUT_OFFSET, 8'hff);
      rd(S45_ANALOG_TEMP_OFFSET, 8'h07);
      rd(8'hec, 8'h00);
   endtask : defaults

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   // Main sequence: defaults, two complementary mask sweeps, then a reset in mid-run.
   initial begin
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      defaults();
      sweep(8'hfa, 8'h5a, 8'hf5);
      sweep(8'h05, 8'ha5, 8'h0a);
      wrrd(S45_INPUT_OFFSET, 8'h3c, 8'h3c);
      wrrd(S3_ANALOG_TEMP_OFFSET, 8'hf9, 8'h09);
      #1 rstn = 1'b0;
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      defaults();
      final_report();
   end
endmodule : sleep_state_error_mask_test
